/* common/adcts_consts.svh */
// Register indices, field positions and reset values of the threshold block
`ifndef ADCTS_CONSTS_SVH
`define ADCTS_CONSTS_SVH
// Register indices; byte address on the bus is four times the index
`define ADCTS_IDX_LTH_L 14'h1d0c
`define ADCTS_IDX_LTH_H 14'h1d0d
`define ADCTS_IDX_UTH_L 14'h1d0e
`define ADCTS_IDX_UTH_H 14'h1d0f
`define ADCTS_IDX_ERR_L 14'h1d10
`define ADCTS_IDX_ERR_H 14'h1d11
`define ADCTS_IDX_STPT_L 14'h1d12
`define ADCTS_IDX_STPT_H 14'h1d13
`define ADCTS_IDX_RES_H 14'h1d1e
`define ADCTS_IDX_PCH 14'h1d1f
`define ADCTS_IDX_CON3 14'h1d29
`define ADCTS_IDX_STAT 14'h1d2a
`define ADCTS_IDX_ACT 14'h1d2c
`define ADCTS_IDX_CGA 14'h1d2e
`define ADCTS_IDX_CGB 14'h1d2f
`define ADCTS_IDX_CGC 14'h1d30
`define ADCTS_IDX_IRQ_STAT 14'h1d40
`define ADCTS_IDX_IRQ_MASK 14'h1d41
// Writable bit masks
`define ADCTS_MASK_CON3 8'h7f
`define ADCTS_MASK_ACT 8'h3f
`define ADCTS_MASK_PCH 8'h3f
`define ADCTS_MASK_CGA 8'h37
`define ADCTS_MASK_CGB 8'hf0
`define ADCTS_MASK_CGC 8'hff
`define ADCTS_MASK_IRQ 8'h03
// Field positions
`define ADCTS_DIFF_LSB 4
`define ADCTS_STAT_UPPER 6
`define ADCTS_STAT_LOWER 5
`define ADCTS_IRQ_THR 0
`define ADCTS_IRQ_TRIG 1
// Reset values
`define ADCTS_RST_WORD 16'h0000
`define ADCTS_RST_BYTE 8'h00
// Trigger codes
`define ADCTS_TRIG_OFF 6'h00
`define ADCTS_TRIG_ERRH_RD 6'h14
`define ADCTS_TRIG_RESH_RD 6'h15
`define ADCTS_TRIG_PCH_WR 6'h16
`define ADCTS_TRIG_LAST 6'h16
`endif

/* common/adcts_pkg.sv */
// Types shared by the threshold and trigger select block
package adcts_pkg;
  typedef enum logic [1:0] {
    ADCTS_BUS_IDLE = 2'b01,
    ADCTS_BUS_ACK = 2'b10
  } adcts_bus_state_t;
  typedef enum logic [2:0] {
    ADCTS_DIFF_RES_PREV = 3'h0,
    ADCTS_DIFF_RES_STPT = 3'h1,
    ADCTS_DIFF_FLT_PREV = 3'h2,
    ADCTS_DIFF_FLT_STPT = 3'h3
  } adcts_diff_t;
  typedef enum logic [2:0] {
    ADCTS_MODE_NEVER = 3'h0,
    ADCTS_MODE_BELOW = 3'h1,
    ADCTS_MODE_NOT_BELOW = 3'h2,
    ADCTS_MODE_INSIDE = 3'h3,
    ADCTS_MODE_OUTSIDE = 3'h4,
    ADCTS_MODE_NOT_ABOVE = 3'h5,
    ADCTS_MODE_ABOVE = 3'h6,
    ADCTS_MODE_ALWAYS = 3'h7
  } adcts_mode_t;
  // Values from the conversion and filter engine
  typedef struct packed {
    logic [15:0] filter;
    logic [15:0] previous;
    logic [15:0] result;
  } adcts_sample_t;
  // Hardware trigger sources; flattened bit k is trigger code k+1
  typedef struct packed {
    logic [3:0] logicCell;
    logic iocFlag;
    logic comparator;
    logic oscillator;
    logic [2:0] pwm;
    logic [1:0] ccp;
    logic timer6;
    logic timer4;
    logic timer3;
    logic timer2;
    logic timer1;
    logic timer0;
    logic pin;
  } adcts_trig_src_t;
endpackage

/* src/adcts_error_error_select_a.sv */
// Setpoint error calculation register
`timescale 1ns/1ps
`include "adcts_consts.svh"
module adcts_error_error_select_a (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [2:0] diffSel, // Error calculation select
  input wire adcts_pkg::adcts_sample_t sample, // Engine values
  input wire logic [15:0] setpoint, // Signed setpoint
  input wire logic check, // Threshold check strobe
  output logic [15:0] errVal, // Signed setpoint error
  output logic errValid // Pulse after a new error
);
  logic [15:0] next_errVal;

  // Difference chosen by the calculation select
  always_comb
  begin
    case (adcts_pkg::adcts_diff_t'(diffSel))
      adcts_pkg::ADCTS_DIFF_RES_PREV:
        next_errVal = sample.result - sample.previous; // RULE_01
      adcts_pkg::ADCTS_DIFF_RES_STPT:
        next_errVal = sample.result - setpoint; // RULE_16
      adcts_pkg::ADCTS_DIFF_FLT_PREV:
        next_errVal = sample.filter - sample.previous;
      default:
        next_errVal = sample.filter - setpoint; // RULE_16
    endcase
  end

  // Error is captured on every threshold check
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      errVal <= `ADCTS_RST_WORD;
    else if (check)
      errVal <= next_errVal; // RULE_01
  end

  // New error marker for the comparator
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      errValid <= 1'b0;
    else
      errValid <= check;
  end

  chk_err_capture: assert property (@(posedge sys_clk) // RULE_01
    disable iff (!arst_n)
    check && diffSel == 3'h1
    |=> errVal == $past(sample.result) - $past(setpoint))
    else $error("error value not captured");
endmodule // adcts_error_error_select_a

/* src/adcts_trig_sel.sv */
// Auto-conversion trigger selector with edge detection
`timescale 1ns/1ps
`include "adcts_consts.svh"
module adcts_trig_sel (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [21:0] events, // Bit k is trigger code k+1
  input wire logic [5:0] sel, // Trigger select code
  input wire logic convEnable, // Converter enabled
  output logic convStart // One-cycle conversion start
);
  logic [21:0] prevEvents;
  logic [21:0] risen;
  logic [5:0] code1;
  logic inRange;

  // Previous level of every source, so a reselect sees no false edge
  generate
    for (genvar i = 0; i < 22; i++)
    begin : g_prev
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
          prevEvents[i] <= 1'b0;
        else
          prevEvents[i] <= events[i];
      end
    end
  endgenerate

  // Rising edges and the selected slot
  assign risen = events & ~prevEvents;
  assign code1 = sel - 6'h01;
  assign inRange = (sel != `ADCTS_TRIG_OFF) && (sel <= `ADCTS_TRIG_LAST);

  // One start per selected edge; code zero and reserved codes are dead
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      convStart <= 1'b0;
    else
      convStart <= convEnable && inRange && risen[code1[4:0]]; // RULE_18
  end

  chk_trig_select: assert property (@(posedge sys_clk) // RULE_06
    disable iff (!arst_n)
    convStart |-> $past(sel) != 6'h00 && $past(sel) <= 6'h16
      && $past(convEnable))
    else $error("start from disabled or reserved trigger");
endmodule // adcts_trig_sel

/* src/adcts_threshold_top.sv */
// Threshold check, trigger select and channel group registers
// Summary of operation
// RULE_01 - Setpoint error is read-only signed 16-bit, method set by select
// RULE_02 - Lower and upper thresholds are signed 16-bit, writable, reset to zero
// RULE_03 - Error is compared with both thresholds to update the two flags
// RULE_04 - Threshold interrupt fires only when the mode's condition is met
// RULE_05 - Each 16-bit register is two byte registers, high and low byte
// RULE_06 - Six-bit trigger select; code zero disables external triggering
// RULE_07 - Code one takes the trigger from the routed input pin
// RULE_08 - Codes two to fifteen pick timers, capture, PWM, oscillator, etc.
// RULE_09 - Codes sixteen to nineteen pick logic cells; 23 and above reserved
// RULE_10 - Code twenty: reading the error high byte starts a conversion
// RULE_11 - Code twenty-one: reading the result high byte starts a conversion
// RULE_12 - Code twenty-two: writing positive channel select starts a conversion
// RULE_13 - Port A group enables at bits 0, 1, 2, 4 and 5
// RULE_14 - Port B group enables at bits 4 to 7
// RULE_15 - Port C group has eight writable enables, reset to zero
// RULE_16 - Signed 16-bit setpoint register serves as error reference
// RULE_17 - Lower flag when error below lower, upper flag when above upper
// RULE_18 - One start per selected trigger event while enabled; others ignored
`timescale 1ns/1ps
`include "adcts_consts.svh"
module adcts_threshold_top (
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic [15:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data, low byte used
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall request
  input wire adcts_pkg::adcts_sample_t sample, // Engine values
  input wire logic checkStrobe, // Threshold check due
  input wire logic convEnable, // Converter enabled
  input wire adcts_pkg::adcts_trig_src_t trigSrc, // Hardware triggers
  output logic convStart, // Conversion start pulse
  output logic [2:0] errorSelect, // Error select field for the engine
  output logic [5:0] positiveChannel, // Positive channel select
  output logic [7:0] groupEnablePortA, // Port A group enables
  output logic [7:0] groupEnablePortB, // Port B group enables
  output logic [7:0] groupEnablePortC, // Port C group enables
  output logic lowerThresholdFlag, // Error below lower threshold
  output logic upperThresholdFlag, // Error above upper threshold
  output logic irq // Level interrupt
);
  adcts_pkg::adcts_bus_state_t busState;
  logic [15:0] lowerThreshold;
  logic [15:0] upperThreshold;
  logic [15:0] setpoint;
  logic [15:0] errVal;
  logic errValid;
  logic [7:0] control3;
  logic [7:0] triggerSelect;
  logic [7:0] irqStatus;
  logic [7:0] irqMask;
  logic [7:0] wrByte;
  logic [31:0] next_readData;
  logic accept;
  logic wrAcc;
  logic rdAcc;
  logic errHighRead;
  logic resHighRead;
  logic chanWrite;
  logic belowLower;
  logic aboveUpper;
  logic thrEvent;

  // Word match of a register index; only aligned words decode
  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [13:0] idx);
    return (addr[15:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Whether the comparison meets the selected interrupt mode
  function automatic logic mode_hit(input logic [2:0] mode,
    input logic below, input logic above);
    case (adcts_pkg::adcts_mode_t'(mode))
      adcts_pkg::ADCTS_MODE_NEVER: return 1'b0;
      adcts_pkg::ADCTS_MODE_BELOW: return below;
      adcts_pkg::ADCTS_MODE_NOT_BELOW: return !below;
      adcts_pkg::ADCTS_MODE_INSIDE: return !below && !above;
      adcts_pkg::ADCTS_MODE_OUTSIDE: return below || above;
      adcts_pkg::ADCTS_MODE_NOT_ABOVE: return !above;
      adcts_pkg::ADCTS_MODE_ABOVE: return above;
      default: return 1'b1;
    endcase
  endfunction

  // Bus slave: one wait cycle, then the access completes
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      busState <= adcts_pkg::ADCTS_BUS_IDLE;
    else
      case (busState)
        adcts_pkg::ADCTS_BUS_IDLE:
          if (avs_read || avs_write)
            busState <= adcts_pkg::ADCTS_BUS_ACK;
        adcts_pkg::ADCTS_BUS_ACK:
          busState <= adcts_pkg::ADCTS_BUS_IDLE;
        default:
          busState <= adcts_pkg::ADCTS_BUS_IDLE;
      endcase
  end

  // Handshake and accepted-access strobes
  assign avs_waitrequest = (avs_read || avs_write)
    && (busState != adcts_pkg::ADCTS_BUS_ACK);
  assign accept = (avs_read || avs_write)
    && (busState == adcts_pkg::ADCTS_BUS_ACK);
  assign wrAcc = accept && avs_write && avs_byteenable[0];
  assign rdAcc = accept && avs_read;
  assign wrByte = avs_writedata[7:0];

  // Side effects of software accesses that can trigger conversions
  assign errHighRead = rdAcc
    && reg_hit(avs_address, `ADCTS_IDX_ERR_H); // RULE_10
  assign resHighRead = rdAcc
    && reg_hit(avs_address, `ADCTS_IDX_RES_H); // RULE_11
  assign chanWrite = accept && avs_write
    && reg_hit(avs_address, `ADCTS_IDX_PCH); // RULE_12

  // Threshold registers, byte by byte
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lowerThreshold <= `ADCTS_RST_WORD; // RULE_02
      upperThreshold <= `ADCTS_RST_WORD;
    end
    else if (wrAcc)
    begin
      if (reg_hit(avs_address, `ADCTS_IDX_LTH_L))
        lowerThreshold[7:0] <= wrByte; // RULE_05
      if (reg_hit(avs_address, `ADCTS_IDX_LTH_H))
        lowerThreshold[15:8] <= wrByte; // RULE_05
      if (reg_hit(avs_address, `ADCTS_IDX_UTH_L))
        upperThreshold[7:0] <= wrByte; // RULE_02
      if (reg_hit(avs_address, `ADCTS_IDX_UTH_H))
        upperThreshold[15:8] <= wrByte; // RULE_02
    end
  end

  // Setpoint register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      setpoint <= `ADCTS_RST_WORD;
    else if (wrAcc)
    begin
      if (reg_hit(avs_address, `ADCTS_IDX_STPT_L))
        setpoint[7:0] <= wrByte; // RULE_16
      if (reg_hit(avs_address, `ADCTS_IDX_STPT_H))
        setpoint[15:8] <= wrByte; // RULE_16
    end
  end

  // Control, trigger select and positive channel registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      control3 <= `ADCTS_RST_BYTE;
      triggerSelect <= `ADCTS_RST_BYTE;
      positiveChannel <= 6'h00;
    end
    else if (wrAcc)
    begin
      if (reg_hit(avs_address, `ADCTS_IDX_CON3))
        control3 <= wrByte & `ADCTS_MASK_CON3;
      if (reg_hit(avs_address, `ADCTS_IDX_ACT))
        triggerSelect <= wrByte & `ADCTS_MASK_ACT; // RULE_06
      if (reg_hit(avs_address, `ADCTS_IDX_PCH))
        positiveChannel <= wrByte[5:0];
    end
  end

  // Channel group enables; unimplemented pins stay zero
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      groupEnablePortA <= `ADCTS_RST_BYTE;
      groupEnablePortB <= `ADCTS_RST_BYTE;
      groupEnablePortC <= `ADCTS_RST_BYTE; // RULE_15
    end
    else if (wrAcc)
    begin
      if (reg_hit(avs_address, `ADCTS_IDX_CGA))
        groupEnablePortA <= wrByte & `ADCTS_MASK_CGA; // RULE_13
      if (reg_hit(avs_address, `ADCTS_IDX_CGB))
        groupEnablePortB <= wrByte & `ADCTS_MASK_CGB; // RULE_14
      if (reg_hit(avs_address, `ADCTS_IDX_CGC))
        groupEnablePortC <= wrByte & `ADCTS_MASK_CGC; // RULE_15
    end
  end

  assign errorSelect = control3[`ADCTS_DIFF_LSB +: 3];

  // Error capture on each threshold check
  adcts_error_error_select_a adcts_error_error_select_a_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .diffSel(errorSelect),
    .sample(sample),
    .setpoint(setpoint),
    .check(checkStrobe),
    .errVal(errVal),
    .errValid(errValid)
  );

  // Signed comparison against both thresholds
  assign belowLower = $signed(errVal) < $signed(lowerThreshold); // RULE_17
  assign aboveUpper = $signed(errVal) > $signed(upperThreshold); // RULE_17
  assign thrEvent = errValid
    && mode_hit(control3[2:0], belowLower, aboveUpper); // RULE_04

  // Status flags follow each fresh comparison
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lowerThresholdFlag <= 1'b0;
      upperThresholdFlag <= 1'b0;
    end
    else if (errValid)
    begin
      lowerThresholdFlag <= belowLower; // RULE_03
      upperThresholdFlag <= aboveUpper; // RULE_03
    end
  end

  // Trigger selection over hardware and software sources
  adcts_trig_sel adcts_trig_sel_inst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .events({chanWrite, resHighRead, errHighRead, trigSrc}), // RULE_07
    .sel(triggerSelect[5:0]), // RULE_08
    .convEnable(convEnable),
    .convStart(convStart) // RULE_09
  );

  // Sticky interrupt status; a new event beats a clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      irqStatus <= `ADCTS_RST_BYTE;
    else
    begin
      irqStatus <= ((wrAcc && reg_hit(avs_address, `ADCTS_IDX_IRQ_STAT))
          ? (irqStatus & ~wrByte) : irqStatus)
        | {6'h00, convStart, thrEvent}; // RULE_04
    end
  end

  // Interrupt mask
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      irqMask <= `ADCTS_RST_BYTE;
    else if (wrAcc && reg_hit(avs_address, `ADCTS_IDX_IRQ_MASK))
      irqMask <= wrByte & `ADCTS_MASK_IRQ;
  end

  assign irq = |(irqStatus & irqMask);

  // Read data selection; unmapped words read zero
  always_comb
  begin
    next_readData = 32'h0000_0000;
    if (avs_address[1:0] == 2'b00)
      case (avs_address[15:2])
        `ADCTS_IDX_LTH_L: next_readData[7:0] = lowerThreshold[7:0];
        `ADCTS_IDX_LTH_H: next_readData[7:0] = lowerThreshold[15:8];
        `ADCTS_IDX_UTH_L: next_readData[7:0] = upperThreshold[7:0];
        `ADCTS_IDX_UTH_H: next_readData[7:0] = upperThreshold[15:8];
        `ADCTS_IDX_ERR_L: next_readData[7:0] = errVal[7:0]; // RULE_05
        `ADCTS_IDX_ERR_H: next_readData[7:0] = errVal[15:8]; // RULE_01
        `ADCTS_IDX_STPT_L: next_readData[7:0] = setpoint[7:0];
        `ADCTS_IDX_STPT_H: next_readData[7:0] = setpoint[15:8];
        `ADCTS_IDX_RES_H: next_readData[7:0] = sample.result[15:8];
        `ADCTS_IDX_PCH: next_readData[7:0] = {2'b00, positiveChannel};
        `ADCTS_IDX_CON3: next_readData[7:0] = control3;
        `ADCTS_IDX_STAT: next_readData[7:0] = {1'b0, upperThresholdFlag,
          lowerThresholdFlag, 5'h00};
        `ADCTS_IDX_ACT: next_readData[7:0] = triggerSelect;
        `ADCTS_IDX_CGA: next_readData[7:0] = groupEnablePortA;
        `ADCTS_IDX_CGB: next_readData[7:0] = groupEnablePortB;
        `ADCTS_IDX_CGC: next_readData[7:0] = groupEnablePortC;
        `ADCTS_IDX_IRQ_STAT: next_readData[7:0] = irqStatus;
        `ADCTS_IDX_IRQ_MASK: next_readData[7:0] = irqMask;
        default: next_readData = 32'h0000_0000;
      endcase
  end

  // Read data captured in the wait cycle, shown when the wait drops
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && busState == adcts_pkg::ADCTS_BUS_IDLE)
      avs_readdata <= next_readData;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  chk_lower_flag: assert property ( // RULE_17
    errValid |=> lowerThresholdFlag
    == ($signed($past(errVal)) < $signed($past(lowerThreshold))))
    else $error("lower flag does not match comparison");
  chk_upper_flag: assert property ( // RULE_03
    errValid |=> upperThresholdFlag
    == ($signed($past(errVal)) > $signed($past(upperThreshold))))
    else $error("upper flag does not match comparison");
  chk_mode_never: assert property ( // RULE_04
    errValid && control3[2:0] == 3'h0
    |=> !irqStatus[0] || $past(irqStatus[0]))
    else $error("threshold interrupt with mode off");
  // A clear in the same cycle must not swallow a new event
  chk_set_wins: assert property ( // RULE_04
    thrEvent |=> irqStatus[`ADCTS_IRQ_THR])
    else $error("threshold event lost");
  chk_start_sticky: assert property ( // RULE_18
    convStart |=> irqStatus[`ADCTS_IRQ_TRIG])
    else $error("conversion start event lost");
  chk_err_read: assert property ( // RULE_10
    errHighRead && convEnable && triggerSelect[5:0] == 6'h14
    |=> convStart)
    else $error("error high read did not trigger");
  chk_res_read: assert property ( // RULE_11
    resHighRead && convEnable && triggerSelect[5:0] == 6'h15
    |=> convStart)
    else $error("result high read did not trigger");
  chk_chan_write: assert property ( // RULE_12
    chanWrite && convEnable && triggerSelect[5:0] == 6'h16
    |=> convStart)
    else $error("channel write did not trigger");
  chk_pin_trigger: assert property ( // RULE_07
    triggerSelect[5:0] == 6'h01 && convEnable && $rose(trigSrc.pin)
    |=> convStart)
    else $error("pin edge did not trigger");
  chk_cgc_write: assert property ( // RULE_15
    wrAcc && reg_hit(avs_address, `ADCTS_IDX_CGC)
    |=> groupEnablePortC == $past(wrByte))
    else $error("port C group write lost");
  chk_cga_mask: assert property ( // RULE_13
    groupEnablePortA[7:6] == 2'b00 && groupEnablePortA[3] == 1'b0)
    else $error("port A reserved bit set");
  chk_bus_wait: assert property ((avs_read || avs_write)
    && !avs_waitrequest |-> $past(avs_waitrequest))
    else $error("access ended without a wait cycle");
endmodule // adcts_threshold_top

/* testbench/adcts_trig_model.sv */
// Model of the hardware trigger sources feeding the block
`timescale 1ns/1ps
module adcts_trig_model (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic fire, // Raise one source
  input wire logic [4:0] code, // Trigger code of that source
  output adcts_pkg::adcts_trig_src_t trigSrc // Source levels
);
  logic [1:0] hold;
  // Chosen source goes high for two cycles, all others stay low
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trigSrc <= '0;
      hold <= 2'h0;
    end
    else if (fire)
    begin
      trigSrc <= adcts_pkg::adcts_trig_src_t'(19'h00001 << (code - 5'h01));
      hold <= 2'h2;
    end
    else if (hold != 2'h0)
    begin
      if (hold == 2'h1)
        trigSrc <= '0;
      hold <= hold - 2'h1;
    end
  end
endmodule // adcts_trig_model

/* testbench/adcts_threshold_top_tb.sv */
// Self-checking bench of the threshold and trigger select block
`timescale 1ns/1ps
`include "adcts_consts.svh"
module adcts_threshold_top_tb;
  logic sysClk;
  logic arstN;
  logic [15:0] address;
  logic rdReq;
  logic wrReq;
  logic [31:0] wrData;
  logic [31:0] rdData;
  logic waitReq;
  adcts_pkg::adcts_sample_t sample;
  logic checkStrobe;
  logic convEnable;
  adcts_pkg::adcts_trig_src_t trigSrc;
  logic convStart;
  logic [5:0] posChan;
  logic [2:0] errSel;
  logic [7:0] grpA;
  logic [7:0] grpB;
  logic [7:0] grpC;
  logic [3:0] byteEn;
  logic lowFlag;
  logic upFlag;
  logic irq;
  logic fire;
  logic [4:0] code;
  logic [7:0] wrVal;
  logic [7:0] stptLo;
  logic [15:0] errVal;
  logic below;
  logic above;
  logic [7:0] hitVec;
  logic [31:0] rdq [$];
  logic [13:0] regIdx [8] = '{`ADCTS_IDX_LTH_L, `ADCTS_IDX_LTH_H,
    `ADCTS_IDX_UTH_L, `ADCTS_IDX_UTH_H, `ADCTS_IDX_CGA, `ADCTS_IDX_CGB,
    `ADCTS_IDX_CGC, `ADCTS_IDX_ACT};
  logic [7:0] regMask [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h37, 8'hf0,
    8'hff, 8'h3f};
  int error_cnt;
  int num_checks;
  int startCnt;
  int snap;
  integer seed;

  adcts_threshold_top adcts_threshold_top_inst (.sys_clk(sysClk),
    .arst_n(arstN), .avs_address(address), .avs_read(rdReq),
    .avs_write(wrReq), .avs_writedata(wrData), .avs_byteenable(byteEn),
    .avs_readdata(rdData), .avs_waitrequest(waitReq), .sample(sample),
    .checkStrobe(checkStrobe), .convEnable(convEnable), .trigSrc(trigSrc),
    .convStart(convStart), .errorSelect(errSel), .positiveChannel(posChan),
    .groupEnablePortA(grpA), .groupEnablePortB(grpB),
    .groupEnablePortC(grpC),
    .lowerThresholdFlag(lowFlag), .upperThresholdFlag(upFlag), .irq(irq));
  adcts_trig_model adcts_trig_model_inst (.sys_clk(sysClk), .arst_n(arstN),
    .fire(fire), .code(code), .trigSrc(trigSrc));

  // Free-running system clock
  initial
  begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic [13:0] idx, input logic rd,
    input logic [7:0] d);
    @(posedge sysClk);
    address <= {idx, 2'b00};
    rdReq <= rd;
    wrReq <= !rd;
    wrData <= {24'h0, d};
    do @(posedge sysClk); while (waitReq);
    rdReq <= 1'b0;
    wrReq <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    bus(idx, 1'b0, d);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [7:0] e);
    rdq.push_back({24'h0, e});
    bus(idx, 1'b1, 8'h00);
  endtask

  task automatic waitStarts(input int n);
    repeat (6) @(posedge sysClk);
    chk(startCnt - snap, n);
  endtask

  // Fire one hardware source and count the starts that follow
  task automatic pulse(input logic [4:0] c, input int n);
    snap = startCnt;
    @(posedge sysClk);
    code <= c;
    fire <= 1'b1;
    @(posedge sysClk);
    fire <= 1'b0;
    waitStarts(n);
  endtask

  // Read answers are matched against the oldest note; starts are counted
  always @(posedge sysClk)
  begin
    if (rdReq && !waitReq)
      chk(rdData, rdq.pop_front());
    if (convStart === 1'b1)
      startCnt++;
  end

  // Watchdog against a hang
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    seed = 32'hf0c48021;
    {address, rdReq, wrReq, wrData, checkStrobe, fire, code} = '0;
    byteEn = 4'h1;
    sample = '0;
    convEnable = 1'b1;
    arstN = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    startCnt = 0;
    repeat (16) @(posedge sysClk);
    arstN <= 1'b1;
    for (int i = 0; i < 7; i++)
      if (i != 4 && i != 5)
        rd(regIdx[i], 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wrVal = 8'($random(seed));
      wr(regIdx[i], wrVal);
      rd(regIdx[i], wrVal & regMask[i]);
    end
    wr(`ADCTS_IDX_ERR_L, 8'hff);
    rd(`ADCTS_IDX_ERR_L, 8'h00);
    rd(14'h1d50, 8'h00);
    // Thresholds -256 and 256, setpoint low byte random and high byte zero, threshold event unmasked
    stptLo = 8'($random(seed));
    wr(`ADCTS_IDX_ACT, 8'h00);
    wr(`ADCTS_IDX_LTH_L, 8'h00);
    wr(`ADCTS_IDX_LTH_H, 8'hff);
    wr(`ADCTS_IDX_UTH_L, 8'h00);
    wr(`ADCTS_IDX_UTH_H, 8'h01);
    wr(`ADCTS_IDX_STPT_L, stptLo);
    wr(`ADCTS_IDX_STPT_H, 8'h00);
    wr(`ADCTS_IDX_IRQ_MASK, 8'h01);
    for (int k = 0; k < 8; k++)
    begin
      wr(`ADCTS_IDX_CON3, {2'b00, k[1:0], 1'b0, k[2:0]});
      @(posedge sysClk);
      sample <= {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
      checkStrobe <= 1'b1;
      @(posedge sysClk);
      checkStrobe <= 1'b0;
      repeat (3) @(posedge sysClk);
      errVal = (k[1] ? sample.filter : sample.result)
        - (k[0] ? {8'h00, stptLo} : sample.previous);
      below = $signed(errVal) < $signed(16'hff00);
      above = $signed(errVal) > $signed(16'h0100);
      hitVec = {1'b1, above, !above, below || above, !below && !above,
        !below, below, 1'b0};
      chk({30'h0, upFlag, lowFlag}, {30'h0, above, below});
      chk({31'h0, irq}, {31'h0, hitVec[k]});
      chk({29'h0, errSel}, {30'h0, k[1:0]});
      rd(`ADCTS_IDX_STAT, {1'b0, above, below, 5'h00});
      rd(`ADCTS_IDX_ERR_L, errVal[7:0]);
      rd(`ADCTS_IDX_ERR_H, errVal[15:8]);
      wr(`ADCTS_IDX_IRQ_STAT, 8'h01);
      @(posedge sysClk);
      chk({31'h0, irq}, 32'h0);
    end
    for (int c = 1; c < 20; c++)
    begin
      wr(`ADCTS_IDX_ACT, 8'(c));
      pulse(5'(c), 1);
      pulse(5'(c % 19 + 1), 0);
    end
    wr(`ADCTS_IDX_ACT, 8'h00);
    pulse(5'h01, 0);
    wr(`ADCTS_IDX_ACT, 8'h17);
    pulse(5'h10, 0);
    wr(`ADCTS_IDX_ACT, 8'h02);
    convEnable <= 1'b0;
    pulse(5'h02, 0);
    convEnable <= 1'b1;
    // Software access triggers
    wr(`ADCTS_IDX_ACT, 8'h14);
    snap = startCnt;
    rd(`ADCTS_IDX_ERR_H, errVal[15:8]);
    waitStarts(1);
    wr(`ADCTS_IDX_ACT, 8'h15);
    snap = startCnt;
    rd(`ADCTS_IDX_RES_H, sample.result[15:8]);
    waitStarts(1);
    wr(`ADCTS_IDX_ACT, 8'h16);
    snap = startCnt;
    wr(`ADCTS_IDX_PCH, 8'h2a);
    waitStarts(1);
    chk({26'h0, posChan}, 32'h2a);
    rd(`ADCTS_IDX_IRQ_STAT, 8'h02);
    // A write without its byte enable must leave the register alone
    byteEn <= 4'h0;
    wr(`ADCTS_IDX_LTH_L, 8'h55);
    byteEn <= 4'h1;
    rd(`ADCTS_IDX_LTH_L, 8'h00);
    wr(`ADCTS_IDX_CGA, 8'hff);
    wr(`ADCTS_IDX_CGB, 8'hff);
    wr(`ADCTS_IDX_CGC, 8'h5a);
    @(posedge sysClk);
    chk({8'h0, grpA, grpB, grpC}, 32'h0037_f05a);
    // Second reset in mid-run clears the registers again
    arstN <= 1'b0;
    repeat (2) @(posedge sysClk);
    arstN <= 1'b1;
    chk({8'h0, grpA, grpB, grpC}, 32'h0);
    rd(`ADCTS_IDX_UTH_H, 8'h00);
    close_out();
  end
endmodule // adcts_threshold_top_tb
